// >>> verilog/irq_bank_pkg.sv
// Package of register offsets, field positions and reset values for the bank
package irq_bank_pkg;
	localparam logic [7:0]  ADDR_CTRL_SECOND = 8'h00;
	localparam logic [7:0]  ADDR_CTRL_THIRD  = 8'h04;
	localparam logic [7:0]  ADDR_SUB_FIRST   = 8'h08;
	localparam logic [7:0]  ADDR_SUB_SECOND  = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h14;
	localparam int          REG_W            = 8;
	localparam int          NUM_SRC          = 15;
	localparam int          FLAG_LSB         = 4;
	localparam logic [7:0]  RST_REG          = 8'h00;
	localparam logic [7:0]  SUB_FIRST_IMPL   = 8'h77;
	localparam logic [14:0] RST_STATUS       = 15'h0000;
	localparam logic [14:0] RST_MASK         = 15'h0000;
endpackage

// >>> verilog/flag_enable_reg.sv
// One 8-bit register: request flags in the high nibble, enables in the low
`timescale 1ns/1ps
module flag_enable_reg
	import irq_bank_pkg::*;
#(
	parameter logic [7:0] IMPL = 8'hff
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic [3:0] set_flags,
	output logic      [7:0] value,
	output logic      [3:0] active
);
	logic [7:0] reg_ff;
	logic [7:0] nxt_reg;

	always_comb begin
		nxt_reg = wr_en ? wr_data : reg_ff;
		// Hardware set wins over a software clear in the same cycle
		nxt_reg[7:4] = nxt_reg[7:4] | set_flags;
		nxt_reg = nxt_reg & IMPL;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_ff <= RST_REG;
		end else begin
			reg_ff <= nxt_reg;
		end
	end

	assign value  = reg_ff;
	assign active = reg_ff[7:4] & reg_ff[3:0];
endmodule // flag_enable_reg

// >>> verilog/interrupt_flag_enable_bank.sv
// APB register bank of group, converter and comparator request flags
// Notes on behaviour
// - Second control bits 7..4: group 4, group 3, converter, group 2 flags
// - Second control bits 3..0: enables in that same order
// - Third control bits 7..4: flags of groups 8, 7, 6, 5
// - Third control bits 3..0: enables of groups 8, 7, 6, 5
// - First sub-register bits 7 and 3 read zero, ignore writes
// - First sub-register bits 6..4: comparator 8, 7, 6 flags
// - First sub-register bits 2..0: comparator 8, 7, 6 enables
// - Second sub-register bits 7..4: comparator 5, 4, 3, 2 flags
// - Second sub-register bits 3..0: comparator 5, 4, 3, 2 enables
`timescale 1ns/1ps
module interrupt_flag_enable_bank
	import irq_bank_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  group_evt_lo,
	input  wire logic [3:0]  group_evt_hi,
	input  wire logic [6:0]  prot_cmp_evt,
	output logic      [3:0]  group_req_lo,
	output logic      [3:0]  group_req_hi,
	output logic      [6:0]  prot_cmp_irq,
	output logic             irq
);
	logic [7:0]  v_second;
	logic [7:0]  v_third;
	logic [7:0]  v_sub1;
	logic [7:0]  v_sub2;
	logic [3:0]  act_second;
	logic [3:0]  act_third;
	logic [3:0]  act_sub1;
	logic [3:0]  act_sub2;
	logic [14:0] status_ff;
	logic [14:0] mask_ff;
	logic [14:0] nxt_status;
	logic [14:0] req_now;
	logic [14:0] req_prev_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        irq_ff;
	logic [3:0]  group_req_lo_ff;
	logic [3:0]  group_req_hi_ff;
	logic [6:0]  prot_cmp_irq_ff;
	logic        setup;
	logic        wr_fire;
	logic [31:0] rd_mux;
	logic        hit;

	function automatic logic wr_to(input logic [7:0] a);
		wr_to = wr_fire && (paddr == a);
	endfunction

	// Answer in the first access cycle: pready rises with the setup edge
	assign setup   = psel && !penable;
	assign wr_fire = psel && penable && pready_ff && pwrite;

	// Inputs are same-clock event pulses from neighbouring logic
	flag_enable_reg #(.IMPL(8'hff)) u_second (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (wr_to(ADDR_CTRL_SECOND)),
		.wr_data  (pwdata[7:0]),
		.set_flags(group_evt_lo),
		.value    (v_second),
		.active   (act_second)
	);
	flag_enable_reg #(.IMPL(8'hff)) u_third (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (wr_to(ADDR_CTRL_THIRD)),
		.wr_data  (pwdata[7:0]),
		.set_flags(group_evt_hi),
		.value    (v_third),
		.active   (act_third)
	);
	flag_enable_reg #(.IMPL(SUB_FIRST_IMPL)) u_sub1 (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (wr_to(ADDR_SUB_FIRST)),
		.wr_data  (pwdata[7:0]),
		.set_flags({1'b0, prot_cmp_evt[6:4]}),
		.value    (v_sub1),
		.active   (act_sub1)
	);
	flag_enable_reg #(.IMPL(8'hff)) u_sub2 (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (wr_to(ADDR_SUB_SECOND)),
		.wr_data  (pwdata[7:0]),
		.set_flags(prot_cmp_evt[3:0]),
		.value    (v_sub2),
		.active   (act_sub2)
	);

	// Comparator index order: bit 6 is comparator 8, bit 0 comparator 2
	assign req_now = {act_sub1[2:0], act_sub2, act_third, act_second};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_req_lo_ff <= 4'h0;
			group_req_hi_ff <= 4'h0;
			prot_cmp_irq_ff <= 7'h00;
		end else begin
			group_req_lo_ff <= act_second;
			group_req_hi_ff <= act_third;
			prot_cmp_irq_ff <= {act_sub1[2:0], act_sub2};
		end
	end

	// Sticky status catches each rising request; set wins over clear
	always_comb begin
		nxt_status = status_ff;
		if (wr_to(ADDR_IRQ_STATUS)) begin
			nxt_status = nxt_status & ~pwdata[14:0];
		end
		nxt_status = nxt_status | (req_now & ~req_prev_ff);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff   <= RST_STATUS;
			req_prev_ff <= 15'h0000;
		end else begin
			status_ff   <= nxt_status;
			req_prev_ff <= req_now;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= RST_MASK;
		end else if (wr_to(ADDR_IRQ_MASK)) begin
			mask_ff <= pwdata[14:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_status & mask_ff);
		end
	end

	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			ADDR_CTRL_SECOND: rd_mux[7:0]  = v_second;
			ADDR_CTRL_THIRD:  rd_mux[7:0]  = v_third;
			ADDR_SUB_FIRST:   rd_mux[7:0]  = v_sub1;
			ADDR_SUB_SECOND:  rd_mux[7:0]  = v_sub2;
			ADDR_IRQ_STATUS:  rd_mux[14:0] = status_ff;
			ADDR_IRQ_MASK:    rd_mux[14:0] = mask_ff;
			default:          hit          = 1'b0;
		endcase
	end

	// Single wait-free access phase; unmapped addresses flag pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup && !hit;
			if (setup && !pwrite) begin
				prdata_ff <= rd_mux;
			end
		end
	end

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign irq          = irq_ff;
	assign group_req_lo = group_req_lo_ff;
	assign group_req_hi = group_req_hi_ff;
	assign prot_cmp_irq = prot_cmp_irq_ff;
endmodule // interrupt_flag_enable_bank

// >>> bench/irq_bank_sva.sv
// Port assertions for the flag and enable bank
`timescale 1ns/1ps
module irq_bank_sva (
	input wire logic       pclk, presetn, psel, penable, pwrite,
	input wire logic       pready, pslverr,
	input wire logic [7:0] paddr,
	input wire logic [3:0] group_req_lo,
	input wire logic [6:0] prot_cmp_evt, prot_cmp_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("setup unanswered");
	answer_single_a: assert property (pready |=> !pready)
		else $error("answer held");
	answer_access_a: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	err_unmapped_a: assert property (psel && !penable && paddr > 8'h14
		|=> pslverr)
		else $error("unmapped accepted");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("stray error");
	// Write lands at the pready edge; the output flop follows one edge later
	cmp_rise_a: assert property ($rose(prot_cmp_irq[0]) |->
		$past(prot_cmp_evt[0]) || $past(prot_cmp_evt[0], 2)
		|| $past(pwrite && pready, 2))
		else $error("request without cause");
	cmp_fall_a: assert property ($fell(prot_cmp_irq[0]) |->
		$past(pwrite && pready, 2))
		else $error("request dropped");
	group_fall_a: assert property ($fell(group_req_lo[0]) |->
		$past(pwrite && pready, 2))
		else $error("group request dropped");
endmodule // irq_bank_sva
bind interrupt_flag_enable_bank irq_bank_sva irq_bank_sva_inst (.*);

// >>> bench/irq_src_model.sv
// Event sources at the bank's far side
`timescale 1ns/1ps
module irq_src_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [14:0] fire,
	output logic      [3:0]  group_evt_lo,
	output logic      [3:0]  group_evt_hi,
	output logic      [6:0]  prot_cmp_evt
);
	// Launched on an edge so the bank never races the bench
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) {prot_cmp_evt, group_evt_hi, group_evt_lo} <= '0;
		else {prot_cmp_evt, group_evt_hi, group_evt_lo} <= fire;
	end
endmodule // irq_src_model

// >>> bench/interrupt_flag_enable_bank_tb_top.sv
// Random and corner-case bench for the flag and enable bank
`timescale 1ns/1ps
module interrupt_flag_enable_bank_tb_top;
	import irq_bank_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0]  paddr, w [4];
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  group_evt_lo, group_evt_hi, group_req_lo, group_req_hi;
	logic [6:0]  prot_cmp_evt, prot_cmp_irq;
	logic [14:0] fire, e;
	logic [3:0]  s1;
	int          err_count, n_compared, cyc;
	interrupt_flag_enable_bank interrupt_flag_enable_bank_inst (.*);
	irq_src_model irq_src_model_inst (.*);
	always #12.5 pclk = ~pclk;
	function automatic logic [7:0] expv(int i, logic [7:0] v, logic [14:0] x);
		logic [3:0] f;
		f = i == 0 ? x[3:0] : i == 1 ? x[7:4] : i == 2 ? {1'b0, x[14:12]} : x[11:8];
		return (v | {f, 4'h0}) & (i == 2 ? SUB_FIRST_IMPL : 8'hff);
	endfunction
	function automatic logic [3:0] act(logic [7:0] v);
		return v[7:4] & v[3:0];
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			$display("ERROR %0t seen %h expected %h", $time, s, x);
			err_count++;
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge keeps two requests off one time step
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		xfer(1'b0, a, 32'h0);
		chk(q, x);
		chk({31'h0, er}, {31'h0, xe});
	endtask
	task automatic conclude;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 3000) begin
			err_count++;
			conclude;
		end
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, fire} = '0;
		void'($urandom(75093));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		repeat (12) begin
			e = 15'($urandom);
			for (int i = 0; i < 4; i++) begin
				w[i] = 8'($urandom);
				xfer(1'b1, 8'(i * 4), {24'h0, w[i]});
			end
			fire <= e;
			@(posedge pclk);
			fire <= '0;
			repeat (3) @(posedge pclk);
			for (int i = 0; i < 4; i++)
				rd(8'(i * 4), {24'h0, expv(i, w[i], e)}, 1'b0);
			s1 = act(expv(2, w[2], e));
			chk({17'h0, prot_cmp_irq, group_req_hi, group_req_lo},
				{17'h0, s1[2:0], act(expv(3, w[3], e)),
				act(expv(1, w[1], e)), act(expv(0, w[0], e))});
		end
		for (int i = 0; i < 4; i++) xfer(1'b1, 8'(i * 4), 32'h0);
		xfer(1'b1, ADDR_IRQ_STATUS, 32'h7fff);
		xfer(1'b1, ADDR_IRQ_MASK, 32'h1);
		xfer(1'b1, ADDR_CTRL_SECOND, 32'h11);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		rd(ADDR_IRQ_STATUS, 32'h1, 1'b0);
		xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, ADDR_IRQ_MASK, 32'h1);
		xfer(1'b1, ADDR_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		conclude;
	end
endmodule // interrupt_flag_enable_bank_tb_top
